// File: hw/cms_pkg.sv
// constants and register map of the charge mode sequencer
package cms_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ        = 200_000_000;
  localparam longint unsigned BOOST_DLY_MS  = 30;
  localparam longint unsigned BOOST_DLY_CYC = BOOST_DLY_MS * CLK_HZ / 1000;
  localparam longint unsigned BLINK_S       = 1;
  localparam longint unsigned BLINK_CYC     = BLINK_S * CLK_HZ;
  localparam longint unsigned WD_S1         = 40;  // arbitrary expiry choices
  localparam longint unsigned WD_S2         = 80;
  localparam longint unsigned WD_S3         = 160;
  localparam longint unsigned WD_CYC1       = WD_S1 * CLK_HZ;
  localparam longint unsigned WD_CYC2       = WD_S2 * CLK_HZ;
  localparam longint unsigned WD_CYC3       = WD_S3 * CLK_HZ;
  localparam int unsigned     INT_PULSE_NS  = 1000;
  localparam int unsigned     INT_PULSE_CYC = INT_PULSE_NS * 200 / 1000;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LIMIT  = 8'h04;
  localparam logic [7:0] ADDR_CHG    = 8'h08;
  localparam logic [7:0] ADDR_SWITCH = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_EFF    = 8'h14;
  // ----------------------------------------------------------------
  // field positions of the control and limit registers
  // ----------------------------------------------------------------
  localparam int CFG_BIT   = 0;   // charge_config_bit
  localparam int BOOST_BIT = 1;   // boost_enable_bit
  localparam int BLIM_BIT  = 2;   // boost_current_select
  localparam int RCHG_BIT  = 3;   // recharge_threshold_select
  localparam int KICK_BIT  = 4;   // watchdog_kick, self clearing
  localparam int WDP_LSB   = 5;   // watchdog period, two bits
  localparam int MON_LSB   = 7;   // status_pin_monitor_mode, two bits
  localparam int SSET_LSB  = 9;   // status pin override, two bits
  localparam int LLI_BIT   = 11;  // light_load_inhibit
  localparam int TRK_LSB   = 28;  // battery_track_offset in limit register
  localparam int IVOS_LSB  = 30;  // input_voltage_limit_offset
  // ----------------------------------------------------------------
  // reset values and fixed currents
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST   = 32'h0000_00A5;
  localparam logic [31:0] LIMIT_RST  = 32'h0000_1194;
  localparam logic [31:0] CHG_RST    = 32'h1070_07BC;
  localparam logic [31:0] SWITCH_RST = 32'h0000_0000;
  localparam logic [15:0] DEF_REGULATION_VOLTAGE_MV   = 16'h1070;  // 4208
  localparam logic [15:0] DEF_FAST_CHARGE_CURRENT_MA   = 16'h07BC;  // 1980
  localparam logic [15:0] IPRE_MA       = 16'h0078;  // 120
  localparam logic [15:0] SHORT_BATTERY_CURRENT_MA     = 16'h005A;  // 90
  localparam logic [15:0] ICLAMP_MA     = 16'h00C8;  // 200
  localparam logic [15:0] SYS_LOW_MV    = 16'h0898;  // 2200
  localparam logic [15:0] BAT_SHORT_MV  = 16'h0898;  // 2200
  localparam logic [15:0] BAT_PRE_MV    = 16'h0BB8;  // 3000
  localparam logic [15:0] RCHG_LO_MV    = 16'h0064;  // 100
  localparam logic [15:0] RCHG_HI_MV    = 16'h00C8;  // 200
  localparam logic [15:0] TRK_200_MV    = 16'h00C8;
  localparam logic [15:0] TRK_250_MV    = 16'h00FA;
  localparam logic [15:0] TRK_300_MV    = 16'h012C;
  localparam logic [15:0] BLIM_LO_MA    = 16'h01F4;  // 500
  localparam logic [15:0] BLIM_HI_MA    = 16'h04B0;  // 1200
  localparam logic [2:0]  BUS_BOOST     = 3'h7;
  typedef enum logic [1:0] {PH_OFF, PH_PRE, PH_FAST, PH_DONE} cms_phase_type;
  typedef enum logic [1:0] {PAT_OFF, PAT_LOW, PAT_B11, PAT_B13} cms_pat_type;
endpackage

// File: hw/cms_stat_blinker.sv
// status pin pattern generator: released, low, or slow blinking
`timescale 1ns/100ps
module cms_stat_blinker #(
  parameter longint unsigned ON_CYC = cms_pkg::BLINK_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] pattern,
  output logic            pin_low
);
  logic [35:0] cnt_q;
  logic [1:0]  pat_q;
  logic [35:0] period;
  logic        wrap;
  logic        low_d;

  // --------------------------------------------------------------
  // blink period and phase decode
  // --------------------------------------------------------------
  assign period = (pattern == cms_pkg::PAT_B13) ? 36'(4 * ON_CYC) : 36'(2 * ON_CYC);
  assign wrap   = (cnt_q >= period - 36'h1) || (pat_q != pattern);
  assign low_d  = (pattern == cms_pkg::PAT_LOW) ||
                  ((pattern[1]) && (cnt_q < 36'(ON_CYC)));

  // counter restarts whenever the requested pattern changes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      pat_q   <= '0;
      pin_low <= 1'b0;
    end else begin
      cnt_q   <= wrap ? '0 : cnt_q + 36'h1;
      pat_q   <= pattern;
      pin_low <= low_d;
    end
  end
endmodule

// File: hw/cms_charge_mode_sequencer.sv
// charge mode sequencer: limits, boost entry, watchdog, charge cycle
// How it works
// - with tracking on, input voltage limit is max(programmed, battery plus offset)
// - tracking offset picks 200, 250 or 300 mV; only while limit offset is 00
// - system below 2.2V clamps input current to min(200mA, programmed limit)
// - boost starts after 30ms of enable bit plus battery, bus and thermistor ok
// - boost current select bit chooses 0.5A or 1.2A
// - bus source status reads 111 during boost
// - reset leaves default mode, registers at reset values, watchdog fault high
// - writing the kick bit enters host mode and clears watchdog fault
// - watchdog period 00 stops the watchdog so host mode stays
// - every kick restarts the watchdog count from zero
// - expiry sets fault, leaves host mode, resets all but switch bits and limits other than the track offset
// - charging needs config bit 1 and charge enable pin low
// - default mode uses 4.208V, 1980mA and 120mA
// - new cycle needs converter, no faults, switch on, enabled, battery below regulation
// - recharge starts below regulation minus 100mV or 200mV per select bit
// - status pin low charging, released done or off, blinking on fault while charging, 11 releases
// - charge phase field: 00 off, 01 pre, 10 fast, 11 done
// - interrupt pin pulses low when a charge cycle completes
// - monitor mode 01 lets override field pick off, low, 1s/1s or 1s/3s blink
// - short current below 2.2V, precharge to 3V, fast above; phases 01, 01, 10
// - in input power regulation termination is held and timer runs half rate
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
module cms_charge_mode_sequencer #(
  parameter longint unsigned BOOST_DLY_CYC = cms_pkg::BOOST_DLY_CYC,
  parameter longint unsigned WD_CYC1       = cms_pkg::WD_CYC1,
  parameter longint unsigned WD_CYC2       = cms_pkg::WD_CYC2,
  parameter longint unsigned WD_CYC3       = cms_pkg::WD_CYC3,
  parameter longint unsigned BLINK_CYC     = cms_pkg::BLINK_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [15:0] BAT_MV,
  input  wire logic [15:0] SYS_MV,
  input  wire logic [2:0]  BUS_SOURCE_CODE,
  input  wire logic        CONV_READY,
  input  wire logic        THERM_FAULT,
  input  wire logic        THERM_BOOST_OK,
  input  wire logic        SAFETY_FAULT,
  input  wire logic        BAT_ABOVE_BOOST_MIN,
  input  wire logic        BUS_BELOW_BAT,
  input  wire logic        TERM_DETECT,
  input  wire logic        INPUT_POWER_REGULATION,
  input  wire logic        TIMER_TICK,
  input  wire logic        CHARGE_ENABLE_N_PIN,
  output logic [15:0]      EFF_VIN_LIMIT_MV,
  output logic [15:0]      EFF_IIN_LIMIT_MA,
  output logic [15:0]      CHARGE_CURRENT_MA,
  output logic [15:0]      REGULATION_VOLTAGE_MV,
  output logic [15:0]      BOOST_LIMIT_MA,
  output logic             BOOST_ACTIVE,
  output logic [2:0]       BUS_SOURCE_STATUS,
  output logic [1:0]       CHARGE_PHASE_FIELD,
  output logic             SAFETY_TIMER_ADVANCE,
  output logic             TERM_ALLOWED,
  output logic             STATUS_PIN_O,
  output logic             STATUS_PIN_OE,
  output logic             INTERRUPT_N_PIN
);
  typedef enum logic [1:0] {CS_OFF, CS_RUN, CS_DONE} cms_state_type;

  // --------------------------------------------------------------
  // registers and state
  // --------------------------------------------------------------
  logic [31:0]   ctrl_q, limit_q, chg_q, sw_q;
  logic          host_q, wd_fault_q;
  logic [35:0]   wd_cnt_q;
  logic [35:0]   boost_cnt_q;
  logic          cen_s1_q, cen_s2_q;
  logic          half_q;
  logic [7:0]    int_cnt_q;
  cms_state_type st_q, st_d;

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  wire setup    = PSEL && !PENABLE;
  wire wr       = PSEL && PENABLE && PWRITE;
  wire mapped   = (PADDR == cms_pkg::ADDR_CTRL) || (PADDR == cms_pkg::ADDR_LIMIT) ||
                  (PADDR == cms_pkg::ADDR_CHG) || (PADDR == cms_pkg::ADDR_SWITCH) ||
                  (PADDR == cms_pkg::ADDR_STATUS) || (PADDR == cms_pkg::ADDR_EFF);
  wire wr_ctrl  = wr && (PADDR == cms_pkg::ADDR_CTRL);
  wire wr_limit = wr && (PADDR == cms_pkg::ADDR_LIMIT);
  wire wr_chg   = wr && (PADDR == cms_pkg::ADDR_CHG);
  wire wr_sw    = wr && (PADDR == cms_pkg::ADDR_SWITCH);
  wire kick     = wr_ctrl && PWDATA[cms_pkg::KICK_BIT];
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // --------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------
  wire       cfg      = ctrl_q[cms_pkg::CFG_BIT];
  wire       boost_en = ctrl_q[cms_pkg::BOOST_BIT];
  wire       blim     = ctrl_q[cms_pkg::BLIM_BIT];
  wire       rchg_sel = ctrl_q[cms_pkg::RCHG_BIT];
  wire [1:0] wd_per   = ctrl_q[cms_pkg::WDP_LSB +: 2];
  wire [1:0] mon      = ctrl_q[cms_pkg::MON_LSB +: 2];
  wire [1:0] sset     = ctrl_q[cms_pkg::SSET_LSB +: 2];
  wire [1:0] trk      = limit_q[cms_pkg::TRK_LSB +: 2];
  wire [1:0] ivos     = limit_q[cms_pkg::IVOS_LSB +: 2];
  wire [15:0] ivl     = limit_q[31:16];
  wire [15:0] icl     = limit_q[15:0];
  wire       force_off = sw_q[0];

  // --------------------------------------------------------------
  // input limits
  // --------------------------------------------------------------
  wire        tracking = (trk != 2'b00) && (ivos == 2'b00);
  wire [15:0] trk_off  = (trk == 2'b01) ? cms_pkg::TRK_200_MV :
                         (trk == 2'b10) ? cms_pkg::TRK_250_MV : cms_pkg::TRK_300_MV;
  wire [15:0] trk_val  = BAT_MV + trk_off;
  wire [15:0] vin_d    = (tracking && (trk_val > ivl)) ? trk_val : ivl;
  wire        sys_low  = SYS_MV < cms_pkg::SYS_LOW_MV;
  wire [15:0] iin_d    = (sys_low && (icl > cms_pkg::ICLAMP_MA)) ?
                         cms_pkg::ICLAMP_MA : icl;

  // --------------------------------------------------------------
  // watchdog
  // --------------------------------------------------------------
  wire [35:0] wd_lim = (wd_per == 2'b01) ? 36'(WD_CYC1) :
                       (wd_per == 2'b10) ? 36'(WD_CYC2) : 36'(WD_CYC3);
  wire        wd_on  = host_q && (wd_per != 2'b00);
  wire        wd_exp = wd_on && (wd_cnt_q >= wd_lim - 36'h1);

  // --------------------------------------------------------------
  // boost entry
  // --------------------------------------------------------------
  wire boost_due = boost_cnt_q == 36'(BOOST_DLY_CYC);
  wire boost_ok  = boost_en && boost_due && BAT_ABOVE_BOOST_MIN &&
                   BUS_BELOW_BAT && THERM_BOOST_OK;

  // --------------------------------------------------------------
  // charge cycle decisions
  // --------------------------------------------------------------
  wire [15:0] regulation_voltage    = host_q ? chg_q[31:16] : cms_pkg::DEF_REGULATION_VOLTAGE_MV;
  wire [15:0] fast_charge_current    = host_q ? chg_q[15:0] : cms_pkg::DEF_FAST_CHARGE_CURRENT_MA;
  wire        chg_en  = cfg && !cen_s2_q;
  wire        run_ok  = chg_en && (fast_charge_current != 16'h0) && !force_off;
  wire        start   = CONV_READY && !THERM_FAULT && !SAFETY_FAULT &&
                        run_ok && (BAT_MV < regulation_voltage);
  wire [15:0] rchg    = regulation_voltage - (rchg_sel ? cms_pkg::RCHG_HI_MV : cms_pkg::RCHG_LO_MV);
  wire        term_ok = TERM_DETECT && !INPUT_POWER_REGULATION && (BAT_MV > rchg);
  wire        fault   = THERM_FAULT || SAFETY_FAULT;
  wire        done_ev = (st_q == CS_RUN) && (st_d == CS_DONE);

  // next charge state
  always_comb begin
    st_d = st_q;
    case (st_q)
      CS_OFF: begin
        if (start) st_d = CS_RUN;
      end
      CS_RUN: begin
        if (!run_ok) st_d = CS_OFF;
        else if (term_ok && !fault) st_d = CS_DONE;
      end
      CS_DONE: begin
        if (!run_ok) st_d = CS_OFF;
        else if ((BAT_MV < rchg) && start) st_d = CS_RUN;
      end
      default: st_d = CS_OFF;
    endcase
  end

  // phase and current picked from battery voltage
  wire        bat_short = BAT_MV < cms_pkg::BAT_SHORT_MV;
  wire        bat_pre   = BAT_MV < cms_pkg::BAT_PRE_MV;
  wire [1:0]  phase_d   = (st_d == CS_OFF) ? 2'(cms_pkg::PH_OFF) :
                          (st_d == CS_DONE) ? 2'(cms_pkg::PH_DONE) :
                          bat_pre ? 2'(cms_pkg::PH_PRE) : 2'(cms_pkg::PH_FAST);
  wire [15:0] icur_d    = ((st_d != CS_RUN) || fault) ? 16'h0 :
                          bat_short ? cms_pkg::SHORT_BATTERY_CURRENT_MA :
                          bat_pre ? cms_pkg::IPRE_MA : fast_charge_current;

  // status pin pattern request
  wire [1:0] pat = (mon == 2'b11) ? 2'(cms_pkg::PAT_OFF) :
                   (mon == 2'b01) ? sset :
                   ((st_q == CS_RUN) && fault) ? 2'(cms_pkg::PAT_B11) :
                   (st_q == CS_RUN) ? 2'(cms_pkg::PAT_LOW) : 2'(cms_pkg::PAT_OFF);

  // --------------------------------------------------------------
  // charge enable pin synchroniser
  // --------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cen_s1_q <= 1'b1;
      cen_s2_q <= 1'b1;
    end else begin
      cen_s1_q <= CHARGE_ENABLE_N_PIN;
      cen_s2_q <= cen_s1_q;
    end
  end

  // --------------------------------------------------------------
  // register file with watchdog soft reset
  // --------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl_q  <= cms_pkg::CTRL_RST;
      limit_q <= cms_pkg::LIMIT_RST;
      chg_q   <= cms_pkg::CHG_RST;
      sw_q    <= cms_pkg::SWITCH_RST;
    end else if (wd_exp) begin
      ctrl_q <= cms_pkg::CTRL_RST;
      chg_q  <= cms_pkg::CHG_RST;
      limit_q[cms_pkg::TRK_LSB +: 2] <= cms_pkg::LIMIT_RST[cms_pkg::TRK_LSB +: 2];
    end else begin
      if (wr_ctrl) ctrl_q <= PWDATA & ~(32'h1 << cms_pkg::KICK_BIT);
      if (wr_limit) limit_q <= PWDATA;
      if (wr_chg) chg_q <= PWDATA;
      if (wr_sw) sw_q <= {29'h0, PWDATA[2:0]};
    end
  end

  // host mode, fault flag and watchdog count; expiry wins over a kick
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      host_q     <= 1'b0;
      wd_fault_q <= 1'b1;
      wd_cnt_q   <= '0;
    end else begin
      if (wd_exp) begin
        host_q     <= 1'b0;
        wd_fault_q <= 1'b1;
        wd_cnt_q   <= '0;
      end else if (kick) begin
        host_q     <= 1'b1;
        wd_fault_q <= 1'b0;
        wd_cnt_q   <= '0;
      end else if (wd_on) begin
        wd_cnt_q <= wd_cnt_q + 36'h1;
      end
    end
  end

  // boost delay counter and boost state
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      boost_cnt_q  <= '0;
      BOOST_ACTIVE <= 1'b0;
    end else begin
      boost_cnt_q  <= !boost_en ? '0 : boost_due ? boost_cnt_q : boost_cnt_q + 36'h1;
      BOOST_ACTIVE <= boost_ok;
    end
  end

  // charge state, interrupt pulse and half rate timer
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_q      <= CS_OFF;
      int_cnt_q <= '0;
      half_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      int_cnt_q <= done_ev ? 8'(cms_pkg::INT_PULSE_CYC) :
                   (int_cnt_q != 8'h0) ? int_cnt_q - 8'h1 : 8'h0;
      half_q    <= TIMER_TICK ? !half_q : half_q;
    end
  end

  // registered outputs
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      EFF_VIN_LIMIT_MV      <= '0;
      EFF_IIN_LIMIT_MA      <= '0;
      CHARGE_CURRENT_MA     <= '0;
      REGULATION_VOLTAGE_MV <= '0;
      BOOST_LIMIT_MA        <= '0;
      BUS_SOURCE_STATUS     <= '0;
      CHARGE_PHASE_FIELD    <= '0;
      SAFETY_TIMER_ADVANCE  <= 1'b0;
      TERM_ALLOWED          <= 1'b0;
      INTERRUPT_N_PIN       <= 1'b1;
    end else begin
      EFF_VIN_LIMIT_MV      <= vin_d;
      EFF_IIN_LIMIT_MA      <= iin_d;
      CHARGE_CURRENT_MA     <= icur_d;
      REGULATION_VOLTAGE_MV <= regulation_voltage;
      BOOST_LIMIT_MA        <= blim ? cms_pkg::BLIM_HI_MA : cms_pkg::BLIM_LO_MA;
      BUS_SOURCE_STATUS     <= boost_ok ? cms_pkg::BUS_BOOST : BUS_SOURCE_CODE;
      CHARGE_PHASE_FIELD    <= phase_d;
      SAFETY_TIMER_ADVANCE  <= TIMER_TICK && (!INPUT_POWER_REGULATION || half_q);
      TERM_ALLOWED          <= !INPUT_POWER_REGULATION;
      INTERRUPT_N_PIN       <= !(done_ev || (int_cnt_q > 8'h1));
    end
  end

  // --------------------------------------------------------------
  // read data, captured in the setup cycle
  // --------------------------------------------------------------
  wire [31:0] status_w = {22'h0, TERM_ALLOWED, (st_q == CS_RUN), BOOST_ACTIVE, host_q,
                          wd_fault_q, BUS_SOURCE_STATUS, CHARGE_PHASE_FIELD};
  wire [31:0] rd_w = (PADDR == cms_pkg::ADDR_CTRL)   ? ctrl_q :
                     (PADDR == cms_pkg::ADDR_LIMIT)  ? limit_q :
                     (PADDR == cms_pkg::ADDR_CHG)    ? chg_q :
                     (PADDR == cms_pkg::ADDR_SWITCH) ? sw_q :
                     (PADDR == cms_pkg::ADDR_STATUS) ? status_w :
                     (PADDR == cms_pkg::ADDR_EFF)    ? {EFF_IIN_LIMIT_MA, EFF_VIN_LIMIT_MV} :
                     32'h0;
  always_ff @(posedge MCLK) begin
    if (!RST_N) PRDATA <= '0;
    else if (setup) PRDATA <= rd_w;
  end

  // --------------------------------------------------------------
  // status pin driver, open drain
  // --------------------------------------------------------------
  cms_stat_blinker #(.ON_CYC(BLINK_CYC)) u_blink (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .pattern (pat),
    .pin_low (STATUS_PIN_OE)
  );
  assign STATUS_PIN_O = 1'b0;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_done; (st_q == CS_RUN) && (st_d == CS_DONE); endsequence
  sequence s_pulse; !INTERRUPT_N_PIN [*8]; endsequence
  property p_track; tracking && (trk_val > ivl) |=> EFF_VIN_LIMIT_MV == $past(trk_val); endproperty
  a_track: assert property (p_track) else $error("tracking limit wrong");
  property p_clamp; sys_low |=> EFF_IIN_LIMIT_MA <= cms_pkg::ICLAMP_MA; endproperty
  a_clamp: assert property (p_clamp) else $error("input clamp missed");
  property p_boost; $rose(BOOST_ACTIVE) |-> $past(boost_due) && $past(boost_en); endproperty
  a_boost: assert property (p_boost) else $error("boost entered early");
  property p_bus; BOOST_ACTIVE |-> BUS_SOURCE_STATUS == cms_pkg::BUS_BOOST; endproperty
  a_bus: assert property (p_bus) else $error("bus status not 111");
  property p_kick; kick && !wd_exp |=> host_q && !wd_fault_q && (wd_cnt_q == 36'h0); endproperty
  a_kick: assert property (p_kick) else $error("kick not taken");
  property p_wdoff; host_q && (wd_per == 2'b00) |=> host_q; endproperty
  a_wdoff: assert property (p_wdoff) else $error("host mode lost");
  property p_exp; wd_exp |=> !host_q && wd_fault_q && (ctrl_q == cms_pkg::CTRL_RST); endproperty
  a_exp: assert property (p_exp) else $error("expiry not handled");
  property p_en; (st_q == CS_RUN) && !chg_en |=> st_q == CS_OFF; endproperty
  a_en: assert property (p_en) else $error("charging while disabled");
  property p_phase; st_q == CS_DONE |-> CHARGE_PHASE_FIELD == 2'b11; endproperty
  a_phase: assert property (p_phase) else $error("phase not 11");
  property p_int; s_done |=> s_pulse; endproperty
  a_int: assert property (p_int) else $error("no interrupt pulse");
  property p_mon; (mon == 2'b11) ##1 (mon == 2'b11) |=> !STATUS_PIN_OE; endproperty
  a_mon: assert property (p_mon) else $error("status pin driven");
  property p_short; (st_d == CS_RUN) && !fault && bat_short |=>
    CHARGE_CURRENT_MA == cms_pkg::SHORT_BATTERY_CURRENT_MA && CHARGE_PHASE_FIELD == 2'b01; endproperty
  a_short: assert property (p_short) else $error("short current wrong");
endmodule

// File: verification/cms_host_model.sv
// host side model: apb master that issues register transfers
`timescale 1ns/100ps
module cms_host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // setup, then access held until pready, at most 17 cycles; the caller counts a timeout
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic t);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    for (int i = 0; (i < 16) && (pready !== 1'b1); i++) @(posedge clk);
    t = (pready !== 1'b1);  // timeout, counted by the caller
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);  // idle cycle so the next call never drives psel twice in one step
  endtask
endmodule

// File: verification/tb_top.sv
// self-checking bench for the charge mode sequencer
`timescale 1ns/100ps
module tb_top;
  logic MCLK = 0, RST_N = 0, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, se, CONV_READY = 1;
  logic THERM_FAULT = 0, SAFETY_FAULT = 0, THERM_BOOST_OK = 1, BAT_ABOVE_BOOST_MIN = 1;
  logic BUS_BELOW_BAT = 1, TERM_DETECT = 0, INPUT_POWER_REGULATION = 0, TIMER_TICK = 0;
  logic CHARGE_ENABLE_N_PIN = 0, BOOST_ACTIVE, SAFETY_TIMER_ADVANCE, TERM_ALLOWED;
  logic STATUS_PIN_O, STATUS_PIN_OE, INTERRUPT_N_PIN, to;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic [15:0] BAT_MV = 16'h0E10, SYS_MV = 16'h0C80, EFF_VIN_LIMIT_MV, EFF_IIN_LIMIT_MA;
  logic [15:0] CHARGE_CURRENT_MA, REGULATION_VOLTAGE_MV, BOOST_LIMIT_MA;
  logic [2:0]  BUS_SOURCE_CODE = 3'h1, BUS_SOURCE_STATUS;
  logic [1:0]  CHARGE_PHASE_FIELD;
  int          err_count = 0, comparisons = 0, lo, n_tick;
  cms_charge_mode_sequencer #(.BOOST_DLY_CYC(20), .WD_CYC1(50), .WD_CYC2(100), .WD_CYC3(200),
    .BLINK_CYC(8)) DUT (.MCLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .BAT_MV, .SYS_MV, .BUS_SOURCE_CODE, .CONV_READY, .THERM_FAULT,
    .THERM_BOOST_OK, .SAFETY_FAULT, .BAT_ABOVE_BOOST_MIN, .BUS_BELOW_BAT, .TERM_DETECT,
    .INPUT_POWER_REGULATION, .TIMER_TICK, .CHARGE_ENABLE_N_PIN, .EFF_VIN_LIMIT_MV,
    .EFF_IIN_LIMIT_MA, .CHARGE_CURRENT_MA, .REGULATION_VOLTAGE_MV, .BOOST_LIMIT_MA,
    .BOOST_ACTIVE, .BUS_SOURCE_STATUS, .CHARGE_PHASE_FIELD, .SAFETY_TIMER_ADVANCE,
    .TERM_ALLOWED, .STATUS_PIN_O, .STATUS_PIN_OE, .INTERRUPT_N_PIN);
  cms_host_model HOST (.clk(MCLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
    .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));
  initial forever #2.5 MCLK = ~MCLK;
  always @(posedge MCLK) TIMER_TICK <= 1'($urandom_range(1, 0));
  // compare, count and report one result
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rg(input logic w, input logic [7:0] a, input logic [31:0] d);
    HOST.xfer(w, a, d, q, se, to);
    if (to) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  // phase and current expected from battery voltage
  function automatic logic [17:0] chg_exp(input logic [15:0] b);
    if (b < 16'h0898) return {2'b01, 16'h005A};
    if (b < 16'h0BB8) return {2'b01, 16'h0078};
    return {2'b10, 16'h07BC};
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(12630));
    tk(6);
    RST_N <= 1'b1;
    tk(4);
    chk("dflt", {2'b10, 16'h07BC, 16'h1070}, {CHARGE_PHASE_FIELD, CHARGE_CURRENT_MA,
        REGULATION_VOLTAGE_MV});
    chk("blim", 16'h04B0, BOOST_LIMIT_MA);
    rg(0, cms_pkg::ADDR_CTRL, 0);
    chk("ctrl", cms_pkg::CTRL_RST, q);
    rg(0, cms_pkg::ADDR_STATUS, 0);
    chk("wdog", 2'b01, q[6:5]);
    rg(1, cms_pkg::ADDR_CTRL, 32'h0000_0095);
    rg(1, cms_pkg::ADDR_LIMIT, 32'h1194_01F4);
    tk(60);
    rg(0, cms_pkg::ADDR_STATUS, 0);
    chk("host", 2'b10, q[6:5]);
    repeat (12) begin
      BAT_MV <= 16'(1500 + $urandom_range(3199, 0));
      SYS_MV <= 16'($urandom_range(4399, 0));
      BUS_SOURCE_CODE <= 3'($urandom_range(6, 0));
      tk(4);
      chk("vin", (BAT_MV + 16'h00C8 > 16'h1194) ? BAT_MV + 16'h00C8 : 16'h1194,
          EFF_VIN_LIMIT_MV);
      chk("iin", SYS_MV < 16'h0898 ? 16'h00C8 : 16'h01F4, EFF_IIN_LIMIT_MA);
      chk("phase", chg_exp(BAT_MV), {CHARGE_PHASE_FIELD, CHARGE_CURRENT_MA});
      chk("bus", BUS_SOURCE_CODE, BUS_SOURCE_STATUS);
    end
    rg(1, cms_pkg::ADDR_CTRL, 32'h0000_0083);
    tk(16);
    chk("early", 0, BOOST_ACTIVE);
    repeat (12) if (BOOST_ACTIVE !== 1'b1) tk(1);
    chk("boost", {1'b1, 3'h7, 16'h01F4}, {BOOST_ACTIVE, BUS_SOURCE_STATUS,
        BOOST_LIMIT_MA});
    rg(1, cms_pkg::ADDR_CTRL, 32'h0000_0001);
    BAT_MV <= 16'h1036;
    TERM_DETECT <= 1'b1;
    INPUT_POWER_REGULATION <= 1'b1;
    tk(2);
    lo = 0;
    n_tick = 0;
    // timer advances against base ticks while regulating
    repeat (40) begin
      @(posedge MCLK);
      lo += int'(SAFETY_TIMER_ADVANCE);
      n_tick += int'(TIMER_TICK);
    end
    chk("half", 1, 32'((2 * lo <= n_tick + 3) && (2 * lo + 3 >= n_tick)));
    chk("hold", {2'b10, 1'b1, 1'b0}, {CHARGE_PHASE_FIELD, STATUS_PIN_OE,
        TERM_ALLOWED});
    INPUT_POWER_REGULATION <= 1'b0;
    tk(3);
    chk("done", {2'b11, 1'b0, 1'b0, 1'b1}, {CHARGE_PHASE_FIELD, INTERRUPT_N_PIN, STATUS_PIN_OE,
        TERM_ALLOWED});
    TERM_DETECT <= 1'b0;
    BAT_MV <= 16'h0FD2;
    tk(4);
    chk("rchg", {2'b10, 1'b1}, {CHARGE_PHASE_FIELD, STATUS_PIN_OE});
    rg(1, cms_pkg::ADDR_CTRL, 32'h0000_0181);
    tk(3);
    chk("mon", 0, STATUS_PIN_OE);
    rg(1, cms_pkg::ADDR_CTRL, 32'h0000_0681);
    tk(3);
    lo = 0;
    // two full 1s on 3s off periods hold a quarter of low cycles
    repeat (64) begin
      @(posedge MCLK);
      lo += int'(STATUS_PIN_OE);
    end
    chk("blink", 16, lo);
    CHARGE_ENABLE_N_PIN <= 1'b1;
    tk(5);
    chk("off", 0, {CHARGE_PHASE_FIELD, CHARGE_CURRENT_MA});
    rg(1, cms_pkg::ADDR_CTRL, 32'h0000_0281);
    tk(3);
    chk("force", 1, STATUS_PIN_OE);
    rg(1, cms_pkg::ADDR_CTRL, 32'h0000_00B1);
    tk(60);
    rg(0, cms_pkg::ADDR_CTRL, 0);
    chk("expiry", cms_pkg::CTRL_RST, q);
    rg(0, 8'h40, 0);
    chk("slverr", 1, se);
    tally_and_finish();
  end
endmodule
